// File: hdl/clk_glitch_switch.sv
// Shared constants and the glitch-free clock source and divider switch.
package osc_pkg;

    // System clock rate and the settling time after a fast oscillator restart.
    localparam int unsigned SYS_CLK_KHZ     = 20000;
    localparam int unsigned FAST_SETTLE_US  = 10;
    localparam int unsigned FAST_SETTLE_CYC = (FAST_SETTLE_US * SYS_CLK_KHZ + 999) / 1000;

    // Oscillator mode register field positions and reset value.
    localparam int unsigned CMC_EXT_CLK_BIT  = 7;
    localparam int unsigned CMC_MAIN_PIN_BIT = 6;
    localparam int unsigned CMC_SUB_PIN_BIT  = 4;
    localparam int unsigned CMC_GAIN_BIT     = 0;
    localparam logic [7:0]  CMC_RW_MASK      = 8'hd1;
    localparam logic [7:0]  CMC_RESET        = 8'h00;

    // Clock select register field positions and reset values.
    localparam int unsigned CKC_SUB_ACT_BIT  = 7;
    localparam int unsigned CKC_SUB_SEL_BIT  = 6;
    localparam int unsigned CKC_MAIN_ACT_BIT = 5;
    localparam int unsigned CKC_MAIN_SEL_BIT = 4;
    localparam int unsigned CKC_DIV_LSB      = 0;
    localparam int unsigned DIV_W            = 3;
    localparam logic [DIV_W-1:0] DIV_RESET   = 3'h0;
    localparam logic [DIV_W-1:0] DIV_MAX     = 3'h5;
    localparam logic [DIV_W-1:0] SUB_DIV_LOG = 3'h1;

    // Run control register field positions and reset value.
    localparam int unsigned CSC_SUB_STOP_BIT  = 6;
    localparam int unsigned CSC_FAST_STOP_BIT = 0;
    localparam logic [7:0]  CSC_RESET         = 8'h40;

    // Option byte field positions.
    localparam int unsigned OPT_WDOG_EN_BIT   = 4;
    localparam int unsigned OPT_WDOG_STBY_BIT = 0;

    // Edge counter width of the switch.
    localparam int unsigned CNT_W = 5;

    // Clock sources of the CPU clock, one-hot.
    typedef enum logic [2:0] {
        SRC_FAST = 3'b001,
        SRC_MAIN = 3'b010,
        SRC_SUB  = 3'b100
    } clk_src_t;

    // Power states, one-hot.
    typedef enum logic [2:0] {
        PWR_RUN  = 3'b001,
        PWR_HALT = 3'b010,
        PWR_STOP = 3'b100
    } pwr_state_t;

    // Source edges per output half period, less one, for a divide by 2 to the div.
    function automatic logic [CNT_W-1:0] half_count(input logic [DIV_W-1:0] div);
        half_count = CNT_W'((32'h1 << div) - 32'h1);
    endfunction

endpackage : osc_pkg

`timescale 1ns/1ns

module clk_glitch_switch
    import osc_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic [2:0]       src_lvl,
    input  wire logic [2:0]       src_run,
    input  clk_src_t              req_src,
    input  wire logic [DIV_W-1:0] req_div,
    output logic                  clk_out,
    output clk_src_t              cur_src,
    output logic [DIV_W-1:0]      cur_div
);

    logic [2:0]       src_dly_q;
    logic [CNT_W-1:0] cnt_q;
    logic             sel_edge;
    logic             cur_dead;
    logic             change;

    ////////////////////////////////////////////////////////////////////////////////
    // Edge detection on the already synchronised source levels.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            src_dly_q <= 3'h0;
        end else begin
            src_dly_q <= src_lvl;
        end
    end

    assign sel_edge = |((src_lvl ^ src_dly_q) & cur_src);
    assign cur_dead = ~|(src_run & cur_src);
    assign change   = (req_src != cur_src) || (req_div != cur_div);

    ////////////////////////////////////////////////////////////////////////////////
    // A change is taken only where the output would rise, so the low phase is
    // stretched and never cut; a dead source is left at once while low.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cnt_q   <= '0;
            clk_out <= 1'b0;
            cur_src <= SRC_FAST;
            cur_div <= DIV_RESET;
        end else if (!clk_out && change && cur_dead) begin
            cnt_q   <= '0;
            cur_src <= req_src;
            cur_div <= req_div;
        end else if (sel_edge) begin
            if (cnt_q == half_count(cur_div)) begin
                cnt_q <= '0;
                if (clk_out) begin
                    clk_out <= 1'b0;
                end else if (change) begin
                    cur_src <= req_src;
                    cur_div <= req_div;
                end else begin
                    clk_out <= 1'b1;
                end
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule // clk_glitch_switch

// File: hdl/osc_source_control.sv
// Oscillator start and stop control with CPU clock source and divider selection.
// What this block does
// - Fast oscillator stop bit: zero restarts the fast oscillator, one stops it.
// - After reset the fast oscillator runs and drives the CPU clock.
// - Main select zero: divider field picks fast oscillator over 2 to the field, 0..5.
// - Stop instruction enters stop mode and halts the fast oscillator.
// - Two status bits show CPU clock: subsystem, else main or fast.
// - Subsystem pins are input port pins after reset until configured.
// - Subsystem pin select bit in the mode register enables crystal oscillation.
// - The oscillator mode register accepts one write only after reset.
// - Clearing the subsystem stop bit starts the subsystem oscillator.
// - Subsystem select bit makes half the subsystem frequency the CPU clock.
// - Subsystem clock also feeds peripherals; converter and two-wire not guaranteed then.
// - Setting the subsystem stop bit stops the subsystem oscillator.
// - Stop mode leaves the subsystem oscillator running.
// - The slow oscillator is never a CPU clock, only the watchdog clock.
// - The slow oscillator starts after reset and drives an enabled watchdog.
// - The slow oscillator keeps running while the watchdog runs; software cannot stop it.
// - Watchdog enable option bit zero stops the slow oscillator for good.
// - Standby-run option zero stops slow oscillator in halt or stop, until release.
// - Main select one: divider picks main clock; largest division refused below 4 MHz.
`timescale 1ns/1ns

module osc_source_control
    import osc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       fast_osc_clk,
    input  wire logic       main_sys_clk,
    input  wire logic       sub_osc_clk,
    input  wire logic       main_clk_running,
    input  wire logic       main_clk_below_4mhz,
    input  wire logic [1:0] sub_port_pins,
    input  wire logic       cmc_wr,
    input  wire logic       ckc_wr,
    input  wire logic       csc_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       stop_exec,
    input  wire logic       halt_enter,
    input  wire logic       standby_release,
    input  wire logic [7:0] wdog_option_byte,
    output logic [7:0]      oscillator_mode_config,
    output logic [7:0]      clock_select_reg,
    output logic [7:0]      osc_run_control,
    output logic            fast_osc_run,
    output logic            sub_osc_run,
    output logic            slow_osc_run,
    output logic            fast_osc_settled,
    output logic            cpu_clk,
    output logic            periph_clk,
    output logic            periph_accuracy_warn,
    output logic            sub_pins_crystal,
    output logic [1:0]      sub_port_data,
    output logic            main_pins_osc,
    output logic            external_clock_select,
    output logic            gain_select,
    output logic            stop_mode,
    output logic            halt_mode
);

    localparam int unsigned SETTLE_W = $clog2(FAST_SETTLE_CYC + 1);

    logic [7:0]          cmc_q;
    logic                cmc_written_q;
    logic                main_source_select_q;
    logic                subsystem_select_q;
    logic [DIV_W-1:0]    divider_q;
    logic                fast_osc_stop_q;
    logic                sub_osc_stop_q;
    logic                wdog_enable_opt_q;
    logic                wdog_standby_run_q;
    logic                opt_loaded_q;
    pwr_state_t          pwr_q;
    logic [2:0]          src_meta_q;
    logic [2:0]          src_sync_q;
    logic [1:0]          port_meta_q;
    logic [1:0]          port_sync_q;
    logic                fast_run_dly_q;
    logic [SETTLE_W-1:0] settle_q;
    logic                fast_run;
    logic                sub_run;
    logic                slow_run;
    logic                div_ok;
    logic                new_main_sel;
    logic                new_sub_sel;
    logic [DIV_W-1:0]    new_div;
    clk_src_t            req_src;
    logic [DIV_W-1:0]    req_div;
    clk_src_t            cur_src;
    logic [DIV_W-1:0]    cur_div;
    logic                sw_clk;
    logic                subsystem_active;
    logic                main_active;

    ////////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for the oscillator levels and the port pins.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            src_meta_q <= 3'h0;
            src_sync_q <= 3'h0;
        end else begin
            src_meta_q <= {sub_osc_clk, main_sys_clk, fast_osc_clk};
            src_sync_q <= src_meta_q;
        end
    end

    // The port pins are sampled the same way before the port data reads them.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            port_meta_q <= 2'h0;
            port_sync_q <= 2'h0;
        end else begin
            port_meta_q <= sub_port_pins;
            port_sync_q <= port_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator mode register: the first write after reset is kept, all
    // later ones are dropped, so every field must go in that one write.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cmc_q         <= CMC_RESET;
            cmc_written_q <= 1'b0;
        end else if (cmc_wr && !cmc_written_q) begin
            cmc_q         <= sfr_wdata & CMC_RW_MASK;
            cmc_written_q <= 1'b1;
        end
    end

    // Pin functions follow the mode register; pins stay port inputs until set.
    assign sub_pins_crystal      = cmc_q[CMC_SUB_PIN_BIT];
    assign main_pins_osc         = cmc_q[CMC_MAIN_PIN_BIT];
    assign external_clock_select = cmc_q[CMC_EXT_CLK_BIT];
    assign gain_select           = cmc_q[CMC_GAIN_BIT];

    // Port data reads the pins only while they are in port mode.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sub_port_data <= 2'h0;
        end else if (sub_pins_crystal) begin
            sub_port_data <= 2'h0;
        end else begin
            sub_port_data <= port_sync_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock select register. A divider code above five is refused, as is the
    // largest division of a main clock slower than 4 MHz; the old one stays.
    assign new_main_sel = sfr_wdata[CKC_MAIN_SEL_BIT];
    assign new_sub_sel  = sfr_wdata[CKC_SUB_SEL_BIT];
    assign new_div      = sfr_wdata[CKC_DIV_LSB +: DIV_W];
    assign div_ok       = (new_div <= DIV_MAX) &&
                          !(new_main_sel && main_clk_below_4mhz && (new_div == DIV_MAX));

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            main_source_select_q <= 1'b0;
            subsystem_select_q   <= 1'b0;
            divider_q            <= DIV_RESET;
        end else if (ckc_wr) begin
            main_source_select_q <= new_main_sel;
            subsystem_select_q   <= new_sub_sel;
            if (div_ok) begin
                divider_q <= new_div;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Run control register: stop bits of the fast and subsystem oscillators.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            fast_osc_stop_q <= CSC_RESET[CSC_FAST_STOP_BIT];
            sub_osc_stop_q  <= CSC_RESET[CSC_SUB_STOP_BIT];
        end else if (csc_wr) begin
            fast_osc_stop_q <= sfr_wdata[CSC_FAST_STOP_BIT];
            sub_osc_stop_q  <= sfr_wdata[CSC_SUB_STOP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Option byte is caught once, in the first cycle after reset release.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            opt_loaded_q       <= 1'b0;
            wdog_enable_opt_q  <= 1'b0;
            wdog_standby_run_q <= 1'b0;
        end else if (!opt_loaded_q) begin
            opt_loaded_q       <= 1'b1;
            wdog_enable_opt_q  <= wdog_option_byte[OPT_WDOG_EN_BIT];
            wdog_standby_run_q <= wdog_option_byte[OPT_WDOG_STBY_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power state: the stop and halt instructions leave run, a release returns.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pwr_q <= PWR_RUN;
        end else begin
            case (pwr_q)
                PWR_RUN: begin
                    if (stop_exec) begin
                        pwr_q <= PWR_STOP;
                    end else if (halt_enter) begin
                        pwr_q <= PWR_HALT;
                    end
                end
                PWR_HALT, PWR_STOP: begin
                    if (standby_release) begin
                        pwr_q <= PWR_RUN;
                    end
                end
                default: begin
                    pwr_q <= PWR_RUN;
                end
            endcase
        end
    end

    assign stop_mode = (pwr_q == PWR_STOP);
    assign halt_mode = (pwr_q == PWR_HALT);

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator enables. Stop mode halts the fast one but not the subsystem one, which
    // answers to its stop bit alone and needs the pins in crystal mode.
    assign fast_run = !fast_osc_stop_q && !stop_mode;
    assign sub_run  = !sub_osc_stop_q && sub_pins_crystal;

    // The slow oscillator has no software stop: only the option byte and a
    // standby with standby-run cleared can hold it; it waits for the option.
    assign slow_run = opt_loaded_q && wdog_enable_opt_q &&
                      !((halt_mode || stop_mode) && !wdog_standby_run_q);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            fast_osc_run <= 1'b1;
            sub_osc_run  <= 1'b0;
            slow_osc_run <= 1'b0;
        end else begin
            fast_osc_run <= fast_run;
            sub_osc_run  <= sub_run;
            slow_osc_run <= slow_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Settling timer after a fast oscillator restart, a help to software that
    // must not switch back to it before the time has passed.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            fast_run_dly_q <= 1'b1;
            settle_q       <= '0;
        end else begin
            fast_run_dly_q <= fast_osc_run;
            if (!fast_osc_run) begin
                settle_q <= SETTLE_W'(FAST_SETTLE_CYC);
            end else if (settle_q != '0) begin
                settle_q <= settle_q - 1'b1;
            end
        end
    end

    // Settled once the count has run out with the oscillator still running.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            fast_osc_settled <= 1'b1;
        end else begin
            fast_osc_settled <= fast_osc_run && fast_run_dly_q && (settle_q == '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Requested source: subsystem over main over fast. The slow oscillator is
    // not wired to the switch at all.
    always_comb begin
        if (subsystem_select_q) begin
            req_src = SRC_SUB;
            req_div = SUB_DIV_LOG;
        end else if (main_source_select_q) begin
            req_src = SRC_MAIN;
            req_div = divider_q;
        end else begin
            req_src = SRC_FAST;
            req_div = divider_q;
        end
    end

    // Glitch-free switch that builds the CPU clock from the synchronised source.
    clk_glitch_switch u_switch (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .src_lvl (src_sync_q),
        .src_run ({sub_osc_run, main_clk_running, fast_osc_run}),
        .req_src (req_src),
        .req_div (req_div),
        .clk_out (sw_clk),
        .cur_src (cur_src),
        .cur_div (cur_div)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Status bits show the source actually in use, not the one requested.
    assign subsystem_active = (cur_src == SRC_SUB);
    assign main_active      = (cur_src == SRC_MAIN);

    // Peripherals share the CPU clock; on the subsystem clock the converter
    // and two-wire interface are flagged as not guaranteed.
    assign cpu_clk              = sw_clk;
    assign periph_clk           = sw_clk;
    assign periph_accuracy_warn = subsystem_active;

    ////////////////////////////////////////////////////////////////////////////////
    // Read-back registers, refreshed every cycle.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            oscillator_mode_config <= CMC_RESET;
            clock_select_reg       <= 8'h00;
            osc_run_control        <= CSC_RESET;
        end else begin
            oscillator_mode_config <= cmc_q;
            clock_select_reg       <= 8'h00;
            clock_select_reg[CKC_SUB_ACT_BIT]          <= subsystem_active;
            clock_select_reg[CKC_SUB_SEL_BIT]          <= subsystem_select_q;
            clock_select_reg[CKC_MAIN_ACT_BIT]         <= main_active;
            clock_select_reg[CKC_MAIN_SEL_BIT]         <= main_source_select_q;
            clock_select_reg[CKC_DIV_LSB +: DIV_W]     <= divider_q;
            osc_run_control                            <= 8'h00;
            osc_run_control[CSC_SUB_STOP_BIT]          <= sub_osc_stop_q;
            osc_run_control[CSC_FAST_STOP_BIT]         <= fast_osc_stop_q;
        end
    end

endmodule // osc_source_control

// File: tb/osc_source_control_assertions.sv
// Concurrent checks on the oscillator source control ports.
`timescale 1ns/1ns
module osc_checker
    import osc_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic       cmc_wr,
    input wire logic       csc_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       stop_exec,
    input wire logic       halt_enter,
    input wire logic       standby_release,
    input wire logic [7:0] wdog_option_byte,
    input wire logic [7:0] oscillator_mode_config,
    input wire logic       fast_osc_run,
    input wire logic       sub_osc_run,
    input wire logic       slow_osc_run,
    input wire logic       stop_mode,
    input wire logic       halt_mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic cmc_done_q;
    // Remembers that the mode register has taken its single write.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) cmc_done_q <= 1'b0;
        else if (cmc_wr) cmc_done_q <= 1'b1;
    end
    // Stop mode held for a second cycle.
    sequence stop_held;
        stop_mode ##1 stop_mode;
    endsequence
    fast_stop_a: assert property (csc_wr && sfr_wdata[0] |-> ##3 !fast_osc_run)
        else $error("fast oscillator runs after stop write");
    stop_entry_a: assert property (stop_exec && !stop_mode && !halt_mode |=> stop_mode)
        else $error("stop request not taken");
    stop_halts_a: assert property (stop_held |-> !fast_osc_run)
        else $error("fast oscillator runs in stop mode");
    sub_kept_a: assert property (stop_mode && !$past(csc_wr) && !$past(csc_wr, 2)
        |-> $stable(sub_osc_run)) else $error("stop mode changed subsystem run");
    cmc_once_a: assert property ($past(cmc_done_q, 3) |-> $stable(oscillator_mode_config))
        else $error("mode register changed after first write");
    slow_off_a: assert property (!wdog_option_byte[4] && $past(rst_b, 3) |-> !slow_osc_run)
        else $error("slow oscillator runs with watchdog off");
    slow_on_a: assert property (wdog_option_byte[4] && $past(rst_b, 3) && !halt_mode
        && !stop_mode && !$past(halt_mode) && !$past(stop_mode) |-> slow_osc_run)
        else $error("slow oscillator stopped while watchdog runs");
    slow_stby_a: assert property (halt_mode ##1 halt_mode && !wdog_option_byte[0]
        |-> !slow_osc_run) else $error("slow oscillator runs in halt");
    wake_a: assert property (standby_release && (stop_mode || halt_mode)
        |=> !stop_mode && !halt_mode) else $error("standby not released");
endmodule // osc_checker

bind osc_source_control osc_checker chk_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .cmc_wr(cmc_wr), .csc_wr(csc_wr), .sfr_wdata(sfr_wdata), .stop_exec(stop_exec),
    .halt_enter(halt_enter), .standby_release(standby_release),
    .wdog_option_byte(wdog_option_byte), .oscillator_mode_config(oscillator_mode_config),
    .fast_osc_run(fast_osc_run), .sub_osc_run(sub_osc_run), .slow_osc_run(slow_osc_run),
    .stop_mode(stop_mode), .halt_mode(halt_mode));

// File: tb/osc_source_control_tb_top.sv
// Self-checking bench for the oscillator source control block.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module osc_source_control_tb_top
    import osc_pkg::*;
;
    logic       sys_clk = 0, rst_b = 0, fast_osc_clk = 0, main_sys_clk = 0, sub_osc_clk = 0;
    logic       main_clk_running = 1, main_clk_below_4mhz = 0, cmc_wr = 0, ckc_wr = 0;
    logic       csc_wr = 0, stop_exec = 0, halt_enter = 0, standby_release = 0;
    logic [1:0] sub_port_pins = 2'h2, port_data;
    logic [7:0] sfr_wdata = 8'h00, wdog_option_byte = 8'h11, omc, csr, orc;
    logic       fast_run, sub_run, slow_run, settled, cpu_clk, warn, crystal, stop_m, halt_m;
    logic       main_pins, ext_sel, gain;
    int         mismatches = 0, checked = 0, n;
    osc_source_control dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .fast_osc_clk(fast_osc_clk),
        .main_sys_clk(main_sys_clk), .sub_osc_clk(sub_osc_clk),
        .main_clk_running(main_clk_running), .main_clk_below_4mhz(main_clk_below_4mhz),
        .sub_port_pins(sub_port_pins), .cmc_wr(cmc_wr), .ckc_wr(ckc_wr), .csc_wr(csc_wr),
        .sfr_wdata(sfr_wdata), .stop_exec(stop_exec), .halt_enter(halt_enter),
        .standby_release(standby_release), .wdog_option_byte(wdog_option_byte),
        .oscillator_mode_config(omc), .clock_select_reg(csr), .osc_run_control(orc),
        .fast_osc_run(fast_run), .sub_osc_run(sub_run), .slow_osc_run(slow_run),
        .fast_osc_settled(settled), .cpu_clk(cpu_clk), .periph_clk(),
        .periph_accuracy_warn(warn), .sub_pins_crystal(crystal), .sub_port_data(port_data),
        .main_pins_osc(main_pins), .external_clock_select(ext_sel), .gain_select(gain),
        .stop_mode(stop_m),
        .halt_mode(halt_m));
    // System clock and three slower, unrelated oscillator waveforms.
    always #25 sys_clk = ~sys_clk;
    always #200 fast_osc_clk = ~fast_osc_clk;
    always #150 main_sys_clk = ~main_sys_clk;
    always #500 sub_osc_clk = ~sub_osc_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #5;
    endtask
    // Register write: kind 0 mode, 1 clock select, 2 run control.
    task automatic wr(input int k, input logic [7:0] d);
        sfr_wdata = d;
        {cmc_wr, ckc_wr, csc_wr} = {k == 0, k == 1, k == 2};
        cyc(1);
        {cmc_wr, ckc_wr, csc_wr} = 3'h0;
        cyc(3);
    endtask
    // Power pulse: kind 0 stop, 1 halt, 2 release.
    task automatic pulse(input int k);
        {stop_exec, halt_enter, standby_release} = {k == 0, k == 1, k == 2};
        cyc(1);
        {stop_exec, halt_enter, standby_release} = 3'h0;
        cyc(2);
    endtask
    task automatic do_reset(input logic [7:0] opt);
        rst_b = 0;
        wdog_option_byte = opt;
        cyc(12);
        rst_b = 1;
        cyc(4);
    endtask
    // Counts system cycles over one full output clock period.
    task automatic period();
        n = 0;
        while (cpu_clk !== 1'b0) cyc(1);
        while (cpu_clk !== 1'b1) cyc(1);
        while (cpu_clk !== 1'b0) begin n++; cyc(1); end
        while (cpu_clk !== 1'b1) begin n++; cyc(1); end
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        `CHK("mode", 8'h00, omc)
        `CHK("select", 8'h00, csr)
        `CHK("run ctl", 8'h40, orc)
        `CHK("fast run", 1'b1, fast_run)
        `CHK("port data", 2'h2, port_data)
        `CHK("slow run", 1'b1, slow_run)
    endtask
    task automatic t_div();
        for (int d = 0; d < 6; d++) begin
            wr(1, 8'(d));
            cyc(300);
            period();
            `CHK("fast period", 8 << d, n)
        end
        wr(1, 8'h06);
        `CHK("div refused", 3'h5, csr[2:0])
        main_clk_below_4mhz = 1;
        wr(1, 8'h15);
        `CHK("main div", 3'h5, csr[2:0])
        main_clk_below_4mhz = 0;
    endtask
    task automatic t_fast();
        cyc(300);
        `CHK("main status", 3'h1, csr[7:5])
        wr(2, 8'h41);
        `CHK("fast stop", 1'b0, fast_run)
        `CHK("run ctl", 8'h41, orc)
        wr(2, 8'h40);
        `CHK("fast restart", 1'b1, fast_run)
        `CHK("not settled", 1'b0, settled)
        cyc(200);
        `CHK("settled", 1'b1, settled)
        wr(1, 8'h00);
        cyc(250);
        `CHK("fast status", 3'h0, csr[7:5])
    endtask
    task automatic t_cmc();
        wr(0, 8'h10);
        `CHK("mode", 8'h10, omc)
        `CHK("crystal", 1'b1, crystal)
        `CHK("main pins", 1'b0, main_pins)
        `CHK("ext clock", 1'b0, ext_sel)
        `CHK("gain", 1'b0, gain)
        `CHK("port data", 2'h0, port_data)
        wr(0, 8'hd1);
        `CHK("mode once", 8'h10, omc)
    endtask
    task automatic t_sub();
        wr(2, 8'h00);
        `CHK("sub run", 1'b1, sub_run)
        cyc(40);
        wr(1, 8'h40);
        cyc(80);
        `CHK("sub status", 1'b1, csr[7])
        `CHK("warn", 1'b1, warn)
        period();
        `CHK("sub period", 40, n)
        pulse(0);
        `CHK("stop", 1'b1, stop_m)
        `CHK("fast halted", 1'b0, fast_run)
        `CHK("sub kept", 1'b1, sub_run)
        pulse(2);
        `CHK("fast back", 1'b1, fast_run)
        wr(1, 8'h00);
        cyc(80);
        `CHK("sub status", 1'b0, csr[7])
        wr(2, 8'h40);
        `CHK("sub stop", 1'b0, sub_run)
    endtask
    task automatic t_slow();
        do_reset(8'h10);
        pulse(1);
        `CHK("slow halt", 1'b0, slow_run)
        pulse(2);
        `CHK("slow back", 1'b1, slow_run)
        do_reset(8'h11);
        pulse(1);
        `CHK("slow kept", 1'b1, slow_run)
        pulse(2);
        do_reset(8'h00);
        `CHK("slow off", 1'b0, slow_run)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog.
    initial begin
        do_reset(8'h11);
        t_defaults();
        t_div();
        t_fast();
        t_cmc();
        t_sub();
        t_slow();
        final_report();
    end
    initial begin
        #3000000;
        mismatches++;
        final_report();
    end
endmodule // osc_source_control_tb_top
